/* File: design/irts_top.v */
// Interrupt flags, routing and periodic tick selection for a CPU core.
// Assumes event inputs are one-cycle pulses on clk, except the
// external pin, which is asynchronous.
//
// Contract
// [RULE1] Writing zero to a flag-clear bit clears that flag; one leaves it.
// [RULE2] Clear bits 2..7: timer0, fast tick, slow tick, external, converter, key.
// [RULE3] Routing bit one sends source to non-maskable, zero to maskable; bit0 timer2.
// [RULE4] After reset every source routes to the maskable request.
// [RULE5] Routing bits 3,4,5,6 serve fast, slow, external, converter sources.
// [RULE6] Routing bit 2 serves timer0, or timer0 stop when stop is enabled.
// [RULE7] Fast code 000 takes divider tap 10, 16 Hz.
// [RULE8] Fast code 001 takes tap 8, 64 Hz; code 010 tap 6, 256 Hz.
// [RULE9] Fast codes 011..110 take taps 4, 3, 2, 1.
// [RULE10] Fast code 111 takes tap 0, 16 kHz.
// [RULE11] Tick config bits 5:3 pick slow rate; code 000 is tap 13, 2 Hz.
// [RULE12] Slow codes step taps 12 down to 6; code 100 is tap 9.
// [RULE13] Slow code 111 takes tap 6, 256 Hz.
// [RULE14] Tick config bit 6 picks external edge; one rising, reset rising.
// [RULE15] Flag register reads pending flags at clear-bit positions, zero at reset.
// [RULE16] Enable register bit per source allows interrupts; all off at reset.
// [RULE17] Tick flag sets on tap rise; request line high while flag enabled, routed.
// [RULE18] Non-maskable request gives a fresh edge for each newly pending event; the code queues at most 15 edges and drops further events.
`timescale 1ns/100ps
`include "irts_consts.vh"

module irts_top #(
  parameter SLOW_DIV = `IRTS_SLOW_DIV
) (
  input  wire                    clk,
  input  wire                    reset,
  input  wire [`IRTS_ADDR_W-1:0] reg_addr,
  input  wire [`IRTS_DATA_W-1:0] reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [`IRTS_DATA_W-1:0] reg_rdata,
  input  wire                    timer2_evt,
  input  wire                    timer1_evt,
  input  wire                    timer0_evt,
  input  wire                    timer0_stop_en,
  input  wire                    timer0_stop_evt,
  input  wire                    conv_evt,
  input  wire                    key_evt,
  input  wire                    external_pin_interrupt,
  output reg                     irq_req,
  output reg                     nmi_req
);

  localparam W = `IRTS_DATA_W;

  // Tap index for each fast tick code.
  function [`IRTS_TAP_W-1:0] fast_tap;
    input [2:0] code;
    begin
      case (code)
        3'h0:    fast_tap = `IRTS_FAST_TAP0;
        3'h1:    fast_tap = `IRTS_FAST_TAP1;
        3'h2:    fast_tap = `IRTS_FAST_TAP2;
        3'h3:    fast_tap = `IRTS_FAST_TAP3;
        3'h4:    fast_tap = `IRTS_FAST_TAP4;
        3'h5:    fast_tap = `IRTS_FAST_TAP5;
        3'h6:    fast_tap = `IRTS_FAST_TAP6;
        default: fast_tap = `IRTS_FAST_TAP7;
      endcase
    end
  endfunction

  // Picks one divider tap by index.
  function tap_pick;
    input [`IRTS_DIV_W-1:0] taps;
    input [`IRTS_TAP_W-1:0] idx;
    begin
      tap_pick = taps[idx];
    end
  endfunction

  // Counts set bits of an event vector.
  function [`IRTS_NMI_CNT_W-1:0] ones;
    input [W-1:0] v;
    integer i;
    begin
      ones = {`IRTS_NMI_CNT_W{1'b0}};
      for (i = 0; i < W; i = i + 1) begin
        ones = ones + {{(`IRTS_NMI_CNT_W-1){1'b0}}, v[i]};
      end
    end
  endfunction

  reg  [W-1:0]              enable_q;
  reg  [W-1:0]              flag_q;
  reg  [W-1:0]              flag_d;
  reg  [W-1:0]              route_q;
  reg  [W-1:0]              tick_q;
  reg  [W-1:0]              set_vec;
  reg  [W-1:0]              clr_mask;
  reg  [W-1:0]              nmi_prev_q;
  reg  [`IRTS_NMI_CNT_W-1:0] nmi_cnt_q;
  reg  [`IRTS_NMI_CNT_W-1:0] nmi_cnt_d;
  reg                       fast_prev_q;
  reg                       slow_prev_q;
  reg                       pin_s1_q;
  reg                       pin_s2_q;
  reg                       pin_s3_q;
  reg                       pin_lvl_q;
  reg                       pin_edge;
  wire [`IRTS_DIV_W-1:0]    div_taps;
  wire                      div_step;
  wire [`IRTS_TAP_W-1:0]    fast_idx;
  wire [`IRTS_TAP_W-1:0]    slow_idx;
  wire                      fast_now;
  wire                      slow_now;
  wire                      fast_rise;
  wire                      slow_rise;
  wire                      pin_rise_pol;
  wire                      timer0_src;
  wire [W-1:0]              pend;
  wire [W-1:0]              nmi_vec;
  wire [W-1:0]              nmi_new;
  wire                      nmi_fire;
  wire                      wr_enable;
  wire                      wr_flag;
  wire                      wr_route;
  wire                      wr_tick;

  irts_rtdiv #(
    .SLOW_DIV (SLOW_DIV),
    .DIV_W    (`IRTS_DIV_W)
  ) u_rtdiv (
    .clk      (clk),
    .reset    (reset),
    .tap_q    (div_taps),
    .step_q   (div_step)
  );

  assign wr_enable = reg_wr && (reg_addr == `IRTS_OFF_ENABLE);
  assign wr_flag   = reg_wr && (reg_addr == `IRTS_OFF_FLAG);
  assign wr_route  = reg_wr && (reg_addr == `IRTS_OFF_ROUTE);
  assign wr_tick   = reg_wr && (reg_addr == `IRTS_OFF_TICK);

  // [RULE7] [RULE8] fast tap decode
  // [RULE9] [RULE10] fast tap decode
  assign fast_idx = fast_tap(tick_q[`IRTS_FAST_MSB:`IRTS_FAST_LSB]);

  // [RULE11] [RULE12] slow tap decode
  // [RULE13] slow tap decode
  assign slow_idx = `IRTS_SLOW_TAP_TOP -
                    {1'b0, tick_q[`IRTS_SLOW_MSB:`IRTS_SLOW_LSB]};

  assign fast_now = tap_pick(div_taps, fast_idx);
  assign slow_now = tap_pick(div_taps, slow_idx);

  // Edges count only just after the divider advanced, so a change of
  // rate code never fakes a tick between two divider steps.
  // [RULE17] tap rise detect
  assign fast_rise = div_step && fast_now && !fast_prev_q;
  assign slow_rise = div_step && slow_now && !slow_prev_q;

  // [RULE14] edge polarity
  assign pin_rise_pol = tick_q[`IRTS_EDGE_BIT];

  // [RULE6] timer0 stop alias
  assign timer0_src = timer0_stop_en ? timer0_stop_evt : timer0_evt;

  always @(posedge clk) begin
    if (reset) begin
      fast_prev_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      fast_prev_q <= fast_now;
      slow_prev_q <= slow_now;
    end
  end

  // The pin is asynchronous; the level moves only once the last two
  // stages agree, and the first stage feeds nothing else.
  always @(posedge clk) begin
    if (reset) begin
      pin_s1_q  <= 1'b0;
      pin_s2_q  <= 1'b0;
      pin_s3_q  <= 1'b0;
      pin_lvl_q <= 1'b0;
    end else begin
      pin_s1_q <= external_pin_interrupt;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_lvl_q <= pin_s3_q;
      end
    end
  end

  // [RULE14] edge detect
  always @* begin
    pin_edge = 1'b0;
    if (pin_s2_q == pin_s3_q && pin_s3_q != pin_lvl_q) begin
      pin_edge = (pin_s3_q == pin_rise_pol);
    end
  end

  // [RULE2] source bit map
  always @* begin
    set_vec                   = {W{1'b0}};
    set_vec[`IRTS_BIT_TIMER2] = timer2_evt;
    set_vec[`IRTS_BIT_TIMER1] = timer1_evt;
    set_vec[`IRTS_BIT_TIMER0] = timer0_src;
    set_vec[`IRTS_BIT_FAST]   = fast_rise;
    set_vec[`IRTS_BIT_SLOW]   = slow_rise;
    set_vec[`IRTS_BIT_PIN]    = pin_edge;
    set_vec[`IRTS_BIT_CONV]   = conv_evt;
    set_vec[`IRTS_BIT_KEY]    = key_evt;
  end

  // An event arriving with its own clear keeps the flag set.
  // [RULE1] write zero clears
  always @* begin
    clr_mask = wr_flag ? ~reg_wdata : {W{1'b0}};
    flag_d   = (flag_q & ~clr_mask) | set_vec;
  end

  // [RULE15] [RULE16] register reset
  // [RULE4] maskable default
  always @(posedge clk) begin
    if (reset) begin
      enable_q <= `IRTS_ENABLE_RST;
      flag_q   <= `IRTS_FLAG_RST;
      route_q  <= `IRTS_ROUTE_RST;
      tick_q   <= `IRTS_TICK_RST;
    end else begin
      flag_q <= flag_d;
      if (wr_enable) begin
        enable_q <= reg_wdata;
      end
      // [RULE3] [RULE5] routing write
      if (wr_route) begin
        route_q <= reg_wdata;
      end
      if (wr_tick) begin
        tick_q <= reg_wdata & `IRTS_TICK_WMASK;
      end
    end
  end

  // [RULE15] register readback
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata <= {W{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `IRTS_OFF_ENABLE: reg_rdata <= enable_q;
        `IRTS_OFF_FLAG:   reg_rdata <= flag_q;
        `IRTS_OFF_ROUTE:  reg_rdata <= route_q;
        `IRTS_OFF_TICK:   reg_rdata <= tick_q;
        default:          reg_rdata <= {W{1'b0}};
      endcase
    end else begin
      reg_rdata <= {W{1'b0}};
    end
  end

  // [RULE16] enable gating
  assign pend = flag_q & enable_q;

  // [RULE3] line split
  assign nmi_vec = pend & route_q;
  assign nmi_new = nmi_vec & ~nmi_prev_q;

  // A pulse is followed by at least one low cycle, so each queued
  // event shows as its own rising edge. Events beyond the queue depth
  // within one burst are dropped, a limit no real program reaches.
  // [RULE18] one edge per event
  assign nmi_fire = (nmi_cnt_q != {`IRTS_NMI_CNT_W{1'b0}}) && !nmi_req;

  always @* begin
    nmi_cnt_d = nmi_cnt_q;
    if (nmi_fire) begin
      nmi_cnt_d = nmi_cnt_d - {{(`IRTS_NMI_CNT_W-1){1'b0}}, 1'b1};
    end
    if ({1'b0, nmi_cnt_d} + {1'b0, ones(nmi_new)} >
        {1'b0, `IRTS_NMI_CNT_MAX}) begin
      nmi_cnt_d = `IRTS_NMI_CNT_MAX;
    end else begin
      nmi_cnt_d = nmi_cnt_d + ones(nmi_new);
    end
  end

  // [RULE17] request lines
  always @(posedge clk) begin
    if (reset) begin
      irq_req    <= 1'b0;
      nmi_req    <= 1'b0;
      nmi_prev_q <= {W{1'b0}};
      nmi_cnt_q  <= {`IRTS_NMI_CNT_W{1'b0}};
    end else begin
      irq_req    <= |(pend & ~route_q);
      nmi_req    <= nmi_fire;
      nmi_prev_q <= nmi_vec;
      nmi_cnt_q  <= nmi_cnt_d;
    end
  end

endmodule // irts_top

/* File: common/irts_consts.vh */
// Constants for the interrupt route and tick select block.
// Assumes a 25 MHz system clock and a 32768 Hz low-speed time base.
`ifndef IRTS_CONSTS_VH
`define IRTS_CONSTS_VH

`define IRTS_ADDR_W       8
`define IRTS_DATA_W       8

`define IRTS_OFF_ENABLE   8'h0c
`define IRTS_OFF_FLAG     8'h0d
`define IRTS_OFF_ROUTE    8'h0e
`define IRTS_OFF_TICK     8'h0f

`define IRTS_BIT_TIMER2   0
`define IRTS_BIT_TIMER1   1
`define IRTS_BIT_TIMER0   2
`define IRTS_BIT_FAST     3
`define IRTS_BIT_SLOW     4
`define IRTS_BIT_PIN      5
`define IRTS_BIT_CONV     6
`define IRTS_BIT_KEY      7

`define IRTS_FAST_LSB     0
`define IRTS_FAST_MSB     2
`define IRTS_SLOW_LSB     3
`define IRTS_SLOW_MSB     5
`define IRTS_EDGE_BIT     6

`define IRTS_TICK_RST     8'h43
`define IRTS_ROUTE_RST    8'h00
`define IRTS_ENABLE_RST   8'h00
`define IRTS_FLAG_RST     8'h00
`define IRTS_TICK_WMASK   8'h7f

`define IRTS_DIV_W        14
`define IRTS_TAP_W        4
`define IRTS_FAST_TAP0    4'ha
`define IRTS_FAST_TAP1    4'h8
`define IRTS_FAST_TAP2    4'h6
`define IRTS_FAST_TAP3    4'h4
`define IRTS_FAST_TAP4    4'h3
`define IRTS_FAST_TAP5    4'h2
`define IRTS_FAST_TAP6    4'h1
`define IRTS_FAST_TAP7    4'h0
`define IRTS_SLOW_TAP_TOP 4'hd

`define IRTS_F_CLK_HZ     25000000
`define IRTS_F_SLOW_HZ    32768
`define IRTS_SLOW_DIV     (`IRTS_F_CLK_HZ / `IRTS_F_SLOW_HZ)
`define IRTS_PRE_W        10

`define IRTS_NMI_CNT_W    4
`define IRTS_NMI_CNT_MAX  4'hf

`endif

/* File: design/irts_rtdiv.v */
// Real-time divider chain clocked by a low-speed enable.
// Assumes one system clock; the low-speed rate is an enable pulse.
`timescale 1ns/100ps
`include "irts_consts.vh"

module irts_rtdiv #(
  parameter SLOW_DIV = `IRTS_SLOW_DIV,
  parameter DIV_W    = `IRTS_DIV_W
) (
  input  wire             clk,
  input  wire             reset,
  output reg  [DIV_W-1:0] tap_q,
  output reg              step_q
);

  reg  [`IRTS_PRE_W-1:0] pre_q;
  wire                   slow_en;

  // The prescale count truncates, so the time base runs a little fast.
  assign slow_en = (pre_q == SLOW_DIV[`IRTS_PRE_W-1:0] - 10'h001);

  always @(posedge clk) begin
    if (reset) begin
      pre_q  <= 10'h000;
      tap_q  <= {DIV_W{1'b0}};
      step_q <= 1'b0;
    end else begin
      step_q <= slow_en;
      if (slow_en) begin
        pre_q <= 10'h000;
        tap_q <= tap_q + {{(DIV_W-1){1'b0}}, 1'b1};
      end else begin
        pre_q <= pre_q + 10'h001;
      end
    end
  end

endmodule // irts_rtdiv

/* File: sim/irts_cpu_model.sv */
// Model of the CPU core that takes the two request lines of irts_top.
// Assumes both requests are registered on the same clock as the core.
`timescale 1ns/100ps
module irts_cpu_model (
  input  wire       clk,
  input  wire       reset,
  input  wire       irq_req,
  input  wire       nmi_req,
  output reg  [7:0] nmi_taken,
  output reg  [7:0] irq_taken
);
  reg nmi_last_q;
  always @(posedge clk) begin
    if (reset) begin
      nmi_taken  <= 8'h00;
      irq_taken  <= 8'h00;
      nmi_last_q <= 1'b0;
    end else begin
      nmi_last_q <= nmi_req;
      if (nmi_req && !nmi_last_q)
        nmi_taken <= nmi_taken + 8'h01;
      if (irq_req)
        irq_taken <= irq_taken + 8'h01;
    end
  end
endmodule // irts_cpu_model

/* File: sim/irts_top_assertions.sv */
// Checker of the read path and request outputs of irts_top.
// Assumes it is bound to irts_top and sees only its ports.
`timescale 1ns/100ps
module irts_checker #(parameter SLOW_DIV = 2) (
  input wire       clk,
  input wire       reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       timer2_evt,
  input wire       irq_req,
  input wire       nmi_req
);
  reg [7:0] en_q;
  reg [7:0] rs_q;
  reg [7:0] tk_q;
  always @(posedge clk) begin
    if (reset) begin
      en_q <= 8'h00;
      rs_q <= 8'h00;
      tk_q <= 8'h43;
    end else if (reg_wr) begin
      if (reg_addr == 8'h0c)
        en_q <= reg_wdata;
      if (reg_addr == 8'h0e)
        rs_q <= reg_wdata;
      if (reg_addr == 8'h0f)
        tk_q <= reg_wdata & 8'h7f;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  // A write in the event cycle could legally change the outcome; writes in both cycles are excluded.
  sequence s_t2_arm;
    timer2_evt && !reg_wr && en_q[0] && !rs_q[0] ##1 !reg_wr;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_read_route: assert property (s_rd(8'h0e) |=> reg_rdata == $past(rs_q))
    else $error("route read back wrong");
  a_read_enable: assert property (s_rd(8'h0c) |=> reg_rdata == $past(en_q))
    else $error("enable read back wrong");
  a_read_tick: assert property (s_rd(8'h0f) |=> reg_rdata == $past(tk_q))
    else $error("tick config read back wrong");
  a_read_unmapped: assert property (reg_rd && reg_addr[7:2] != 6'h03 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_cause: assert property (irq_req |-> ($past(en_q & ~rs_q) != 8'h00))
    else $error("irq without enabled maskable source");
  a_timer2_irq: assert property (s_t2_arm |=> irq_req)
    else $error("timer2 event gave no irq");
  a_nmi_single: assert property (nmi_req |=> !nmi_req)
    else $error("nmi pulse longer than one cycle");
  a_reset_quiet: assert property ($fell(reset) |-> !irq_req && !nmi_req)
    else $error("request high out of reset");
endmodule // irts_checker

bind irts_top irts_checker #(.SLOW_DIV(SLOW_DIV)) u_chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer2_evt(timer2_evt), .irq_req(irq_req), .nmi_req(nmi_req)
);

/* File: sim/irts_testbench.sv */
// Self-checking bench for irts_top with a CPU model on its request lines.
// Assumes a 25 MHz clock and a divider step shortened to SLOW_DIV clocks.
`timescale 1ns/100ps
module testbench;
  localparam integer SLOW_DIV = 2;
  reg        clk       = 1'b0;
  reg        reset     = 1'b1;
  reg  [7:0] reg_addr  = 8'h00;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr    = 1'b0;
  reg        reg_rd    = 1'b0;
  reg  [7:0] evt       = 8'h00;
  reg        stop_en   = 1'b0;
  reg        pin       = 1'b0;
  wire [7:0] reg_rdata;
  wire       irq_req;
  wire       nmi_req;
  wire [7:0] nmi_taken;
  wire [7:0] irq_taken;
  integer    failures    = 0;
  integer    check_count = 0;
  reg  [7:0] v;
  reg  [7:0] c0;
  integer    i;
  always #20 clk = ~clk;
  irts_top #(.SLOW_DIV(SLOW_DIV)) dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer2_evt(evt[0]), .timer1_evt(evt[1]),
    .timer0_evt(evt[2]), .timer0_stop_en(stop_en), .timer0_stop_evt(evt[3]), .conv_evt(evt[6]),
    .key_evt(evt[7]), .external_pin_interrupt(pin), .irq_req(irq_req), .nmi_req(nmi_req)
  );
  irts_cpu_model cpu (.clk(clk), .reset(reset), .irq_req(irq_req), .nmi_req(nmi_req),
    .nmi_taken(nmi_taken), .irq_taken(irq_taken));
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [95:0] name, input [15:0] exp, input [15:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      v = reg_rdata;
    end
  endtask
  task pulse(input [7:0] m);
    begin
      @(posedge clk);
      evt <= m;
      @(posedge clk);
      evt <= 8'h00;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task set_pin(input b);
    begin
      @(posedge clk);
      pin <= b;
      repeat (8) @(posedge clk);
    end
  endtask
  // Counts edges until irq_req has been seen low and then high again.
  task wait_rise(input integer lim, inout integer n);
    reg seen_low;
    begin
      seen_low = 1'b0;
      while (!(seen_low && irq_req === 1'b1)) begin
        @(posedge clk);
        #1;
        n = n + 1;
        if (irq_req === 1'b0)
          seen_low = 1'b1;
        if (n > lim) begin
          failures = failures + 1;
          print_verdict;
        end
      end
    end
  endtask
  task t_reset;
    begin
      rd(8'h0c);
      chk("enable", 16'h0000, {8'h00, v});
      rd(8'h0d);
      chk("flags", 16'h0000, {8'h00, v});
      rd(8'h0e);
      chk("route", 16'h0000, {8'h00, v});
      rd(8'h0f);
      chk("tick cfg", 16'h0043, {8'h00, v});
      rd(8'h20);
      chk("unmapped", 16'h0000, {8'h00, v});
    end
  endtask
  task t_route;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        if (i < 3 || i > 5) begin
          wr(8'h0c, 8'h01 << i);
          wr(8'h0e, 8'h01 << i);
          wr(8'h0d, 8'h00);
          c0 = nmi_taken;
          pulse(8'h01 << i);
          chk("nmi count", {8'h00, c0 + 8'h01}, {8'h00, nmi_taken});
          chk("irq", 16'h0000, {15'h0000, irq_req});
        end
      end
      wr(8'h0c, 8'h81);
      wr(8'h0e, 8'h80);
      rd(8'h0e);
      chk("route", 16'h0080, {8'h00, v});
      // The key flag is still pending from the loop, so it is cleared to make its next event new.
      wr(8'h0d, 8'h00);
      c0 = nmi_taken;
      pulse(8'h81);
      chk("irq", 16'h0001, {15'h0000, irq_req});
      chk("nmi count", {8'h00, c0 + 8'h01}, {8'h00, nmi_taken});
      wr(8'h0d, 8'h00);
      wr(8'h0e, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk("irq cleared", 16'h0000, {15'h0000, irq_req});
      c0 = irq_taken;
      pulse(8'h80);
      chk("irq key", 16'h0001, {15'h0000, irq_req});
      // The level stands from the second edge after the pulse, so the core sees it three times.
      chk("irq count", {8'h00, c0 + 8'h03}, {8'h00, irq_taken});
    end
  endtask
  task t_clear;
    begin
      wr(8'h0c, 8'h00);
      wr(8'h0d, 8'h00);
      pulse(8'hc4);
      rd(8'h0d);
      chk("flags", 16'h00c4, {8'h00, v & 8'he7});
      wr(8'h0d, 8'hfb);
      rd(8'h0d);
      chk("flags", 16'h00c0, {8'h00, v & 8'he7});
      wr(8'h0d, 8'h3f);
      rd(8'h0d);
      chk("flags", 16'h0000, {8'h00, v & 8'he7});
      set_pin(1'b1);
      rd(8'h0d);
      chk("pin rise", 16'h0020, {8'h00, v & 8'he7});
      wr(8'h0d, 8'hdf);
      wr(8'h0f, 8'h03);
      set_pin(1'b0);
      rd(8'h0d);
      chk("pin fall", 16'h0020, {8'h00, v & 8'he7});
      wr(8'h0d, 8'hdf);
      set_pin(1'b1);
      rd(8'h0d);
      chk("pin no rise", 16'h0000, {8'h00, v & 8'he7});
      wr(8'h0f, 8'h43);
      stop_en <= 1'b1;
      pulse(8'h04);
      pulse(8'h08);
      rd(8'h0d);
      chk("stop flag", 16'h0004, {8'h00, v & 8'he7});
      stop_en <= 1'b0;
    end
  endtask
  task tick_rate(input integer b, input [7:0] cfg, input integer tap);
    integer n;
    begin
      wr(8'h0f, cfg);
      wr(8'h0c, 8'h01 << b);
      wr(8'h0d, 8'h00);
      n = 0;
      wait_rise((SLOW_DIV << (tap + 2)) + 20, n);
      wr(8'h0d, ~(8'h01 << b));
      n = 2;
      wait_rise((SLOW_DIV << (tap + 2)) + 20, n);
      chk("tick period", SLOW_DIV << (tap + 1), n[15:0]);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_route;
    t_clear;
    for (i = 0; i < 8; i = i + 1)
      tick_rate(3, {5'b01000, i[2:0]}, (i == 0) ? 10 : (i == 1) ? 8 : (i == 2) ? 6 : 7 - i);
    tick_rate(4, 8'h78, 6);
    tick_rate(4, 8'h60, 9);
    tick_rate(4, 8'h40, 13);
    print_verdict;
  end
endmodule // testbench
